// ==== core/dsd_datapath.sv ====
`timescale 1ns/1ns
`default_nettype none
module dsd_datapath import dsd_pkg::*; #(
  parameter logic [31:0] POLY  = CRC_POLY,   // check code generator
  parameter logic [7:0]  TRIES = TRIES_RST   // ID fields read before giving up
) (
  input  wire logic          clk,         // 10 MHz core clock
  input  wire logic          reset_n,     // async reset, active low
  input  wire dsd_lbus_req_t lb_req,      // local bus request
  output var  dsd_lbus_rsp_t lb_rsp,      // local bus answer
  output var  dsd_sel_t      sel,         // decoded select strobes
  input  wire dsd_drv_in_t   drv_in,      // drive status and serial read pair
  output var  dsd_drv_out_t  drv_out,     // drive control and serial write pair
  output var  logic [7:0]    err_status   // error status byte
);

  // ********
  // state
  // ********
  typedef struct packed {
    dsd_state_t    st;
    logic [1:0]    op;
    logic [1:0]    s_dclk;
    logic [1:0]    s_rdp;
    logic [1:0]    s_rdn;
    logic [1:0]    s_rdy;
    logic [1:0]    s_flt;
    logic          dclk_q;
    logic [5:0]    bitc;
    logic [15:0]   cnt;
    logic [15:0]   words;
    logic [31:0]   sh;
    logic [31:0]   crc;
    logic [31:0]   idr;
    logic [31:0]   tid;
    logic [15:0]   gap0;
    logic [15:0]   gap1;
    logic [15:0]   gap2;
    logic [15:0]   secw;
    logic [7:0]    tries;
    logic [15:0]   wbuf;
    logic          wbuf_v;
    logic [15:0]   rbuf;
    logic          rbuf_v;
    logic [7:0]    err;
    logic          done;
    logic          under;
    logic          over;
    logic          nfound;
    logic          push;
    logic [15:0]   push_d;
    logic          ram_pend;
    dsd_lbus_rsp_t rsp;
    dsd_sel_t      sel;
    dsd_drv_out_t  drv;
  } dsd_core_t;

  dsd_core_t    r;
  dsd_core_t    n;
  logic         f_rdy;
  logic         f_ov;
  logic [15:0]  f_od;
  logic [15:0]  ram_rd;
  logic         ram_we;

  // ********
  // helpers
  // ********
  function automatic dsd_region_t region(input logic [15:0] a);
    if (a <= ROM_HI) return RG_ROM;
    if (a >= RAM_LO && a <= RAM_HI) return RG_RAM;
    if (a >= DISK_LO && a <= DISK_HI) return RG_DISK;
    if (a >= IO_LO && a <= IO_HI) return RG_IO;
    return RG_NONE;
  endfunction

  // one shift of the serial check code; the generator sets burst reach
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
    return {c[30:0], 1'b0} ^ ((c[31] ^ b) ? POLY : 32'h00000000);  // see R10
  endfunction

  // ********
  // sub-blocks
  // ********
  // read words wait here while the read buffer is still full
  dsd_fifo2 #(.W(16)) u_rx_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (r.push),
    .in_data   (r.push_d),
    .in_ready  (f_rdy),
    .out_valid (f_ov),
    .out_data  (f_od),
    .out_ready (~r.rbuf_v)
  );

  assign ram_we = lb_req.req && lb_req.we && (region(lb_req.addr) == RG_RAM);

  // 1K words = 2K bytes of sector buffer
  dsd_ram #(.AW(RAM_AW), .DW(16)) u_ram (  // see R14
    .clk   (clk),
    .we    (ram_we),
    .addr  (lb_req.addr[RAM_AW:1]),
    .wdata (lb_req.wdata),
    .rdata (ram_rd)
  );

  // ********
  // next state
  // ********
  always_comb begin
    logic        dk;
    logic        rx;
    logic        b;
    logic        wr;
    logic        fin;
    logic        retry;
    logic        wld;
    logic [15:0] word;
    dk    = 1'b0;
    rx    = 1'b0;
    b     = 1'b0;
    wr    = 1'b0;
    fin   = 1'b0;
    retry = 1'b0;
    wld   = 1'b0;
    word  = 16'h0000;
    n = r;
    n.push = 1'b0;
    n.rsp.ack = 1'b0;
    n.sel = '0;

    // pins pass two flops; only the second stage is read
    n.s_dclk = {r.s_dclk[0], drv_in.dclk};
    n.s_rdp  = {r.s_rdp[0], drv_in.rd_p};
    n.s_rdn  = {r.s_rdn[0], drv_in.rd_n};
    n.s_rdy  = {r.s_rdy[0], drv_in.ready};
    n.s_flt  = {r.s_flt[0], drv_in.fault};
    n.dclk_q = r.s_dclk[1];
    dk = r.s_dclk[1] & ~r.dclk_q;
    rx = r.s_rdp[1] & ~r.s_rdn[1];  // see R6

    // local bus decode and register access
    if (r.ram_pend) begin
      n.ram_pend = 1'b0;
      n.rsp.ack = 1'b1;
      n.rsp.rdata = ram_rd;
    end
    if (lb_req.req) begin
      case (region(lb_req.addr))  // see R2
        RG_ROM: n.sel.rom = 1'b1;
        RG_IO: n.sel.io = 1'b1;
        RG_RAM: begin
          n.sel.ram = 1'b1;
          if (lb_req.we) begin
            n.rsp.ack = 1'b1;
          end else begin
            n.ram_pend = 1'b1;
          end
        end
        RG_DISK: begin
          n.sel.disk = 1'b1;
          n.rsp.ack = 1'b1;
          n.rsp.rdata = 16'h0000;
          if (lb_req.we) begin
            case (lb_req.addr)
              A_WBUF: wld = 1'b1;  // see R1
              A_TID_LO: n.tid[15:0] = lb_req.wdata;
              A_TID_HI: n.tid[31:16] = lb_req.wdata;
              A_GAP0: n.gap0 = lb_req.wdata;  // see R12
              A_GAP1: n.gap1 = lb_req.wdata;  // see R12
              A_GAP2: n.gap2 = lb_req.wdata;  // see R12
              A_SECW: n.secw = lb_req.wdata;
              A_STAT: begin
                n.done   = r.done & ~lb_req.wdata[1];
                n.under  = r.under & ~lb_req.wdata[4];
                n.over   = r.over & ~lb_req.wdata[5];
                n.nfound = r.nfound & ~lb_req.wdata[6];
              end
              A_CMD: begin
                if (r.st == ST_IDLE && lb_req.wdata[1:0] != 2'h0) begin
                  n.op = lb_req.wdata[1:0];
                  n.st = ST_START;
                  n.err = 8'h00;
                end
              end
              default: ;
            endcase
          end else begin
            case (lb_req.addr)
              A_RBUF: begin
                n.rsp.rdata = r.rbuf;
                n.rbuf_v = 1'b0;
              end
              A_STAT: n.rsp.rdata = {9'h000, r.nfound, r.over, r.under, r.rbuf_v, r.wbuf_v, r.done,
                                     r.st != ST_IDLE};
              A_ERR: n.rsp.rdata = {8'h00, r.err};
              A_TID_LO: n.rsp.rdata = r.tid[15:0];
              A_TID_HI: n.rsp.rdata = r.tid[31:16];
              A_GAP0: n.rsp.rdata = r.gap0;
              A_GAP1: n.rsp.rdata = r.gap1;
              A_GAP2: n.rsp.rdata = r.gap2;
              A_SECW: n.rsp.rdata = r.secw;
              default: ;
            endcase
          end
        end
        default: ;
      endcase
    end

    // read buffer refills from the queue once the processor empties it
    if (f_ov && !r.rbuf_v) begin
      n.rbuf = f_od;  // see R4, R5
      n.rbuf_v = 1'b1;
    end

    // disk sequencer; every field step waits for a disk clock edge
    wr = (r.op != CMD_READ);
    case (r.st)
      ST_IDLE: ;
      ST_START: begin
        if (r.s_rdy[1]) begin  // see R13
          n.drv.write_gate = (r.op == CMD_FORMAT);
          n.drv.read_gate = (r.op != CMD_FORMAT);
          n.st = ST_GAP0;
          n.cnt = r.gap0;
          n.tries = TRIES;
        end
      end
      ST_GAP0, ST_GAP1, ST_GAP2: begin
        if (dk) begin
          if (r.cnt == 16'h0000) begin  // see R11
            n.bitc = 6'h00;
            n.crc = CRC_INIT;
            n.words = r.secw;
            case (r.st)
              ST_GAP0: n.st = ST_IDF;
              ST_GAP1: n.st = ST_DATF;
              default: fin = 1'b1;
            endcase
          end else begin
            n.cnt = r.cnt - 16'h0001;
          end
        end
      end
      ST_IDF: begin
        if (dk) begin
          wr = (r.op == CMD_FORMAT);
          n.bitc = r.bitc + 6'h01;
          if (!r.bitc[5]) begin
            b = wr ? r.tid[~r.bitc[4:0]] : rx;  // see R7
            n.crc = crc_step(r.crc, b);
            n.sh = {r.sh[30:0], b};
            if (r.bitc == 6'd31) begin
              n.idr = {r.sh[30:0], b};
            end
          end else if (wr) begin
            b = r.crc[31];  // see R9
            n.crc = {r.crc[30:0], 1'b0};
          end else begin
            n.sh = {r.sh[30:0], rx};
          end
          if (r.bitc == 6'd63) begin
            if (wr) begin
              n.st = ST_GAP1;
              n.cnt = r.gap1;
            end else if ({r.sh[30:0], rx} != r.crc) begin
              n.err[ERR_ID_ECC] = 1'b1;  // see R15, R17
              retry = 1'b1;
            end else if (r.idr == r.tid) begin
              n.st = ST_GAP1;  // see R8
              n.cnt = r.gap1;
              if (r.op == CMD_WRITE) begin
                n.drv.write_gate = 1'b1;
                n.drv.read_gate = 1'b0;
              end
            end else begin
              if (r.idr[31:16] != r.tid[31:16]) begin
                n.err[ERR_CYL] = 1'b1;  // see R16
              end
              retry = 1'b1;
            end
          end
        end
      end
      ST_DATF: begin
        if (dk) begin
          n.bitc = r.bitc + 6'h01;
          if (wr) begin
            if (r.bitc == 6'h00) begin
              word = r.wbuf_v ? r.wbuf : 16'h0000;  // see R3, R5
              n.under = n.under | ~r.wbuf_v;
              n.wbuf_v = 1'b0;
            end else begin
              word = r.sh[15:0];
            end
            b = word[15];
            n.sh = {16'h0000, word[14:0], 1'b0};
          end else begin
            b = rx;
            n.sh = {r.sh[30:0], rx};
            if (r.bitc == 6'd15) begin
              n.push = f_rdy;  // see R4
              n.push_d = {r.sh[14:0], rx};
              n.over = n.over | ~f_rdy;
            end
          end
          n.crc = crc_step(r.crc, b);  // see R9, R17
          if (r.bitc == 6'd15) begin
            n.bitc = 6'h00;
            n.words = r.words - 16'h0001;
            if (r.words == 16'h0001) begin
              n.st = ST_ECCF;
            end
          end
        end
      end
      ST_ECCF: begin
        if (dk) begin
          n.bitc = r.bitc + 6'h01;
          if (wr) begin
            b = r.crc[31];  // see R9
            n.crc = {r.crc[30:0], 1'b0};
          end else begin
            n.sh = {r.sh[30:0], rx};
          end
          if (r.bitc == 6'd31) begin
            if (wr) begin
              n.st = ST_GAP2;
              n.cnt = r.gap2;
            end else begin
              n.err[ERR_DATA_ECC] = r.err[ERR_DATA_ECC] | ({r.sh[30:0], rx} != r.crc);  // see R15, R17
              fin = 1'b1;
            end
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // search gives up after a fixed number of ID fields
    if (retry) begin
      if (r.tries <= 8'h01) begin
        n.nfound = 1'b1;
        fin = 1'b1;
      end else begin
        n.tries = r.tries - 8'h01;
        n.st = ST_GAP0;
        n.cnt = r.gap0;
      end
    end

    // a drive fault aborts whatever is in flight
    if (r.st != ST_IDLE && r.s_flt[1]) begin
      n.err[ERR_FAULT] = 1'b1;  // see R13
      fin = 1'b1;
    end
    if (fin) begin
      n.st = ST_IDLE;
      n.done = 1'b1;
      n.drv.write_gate = 1'b0;
      n.drv.read_gate = 1'b0;
    end

    // serial write pair changes only on disk clock edges
    if (dk) begin
      n.drv.wr_p = b & n.drv.write_gate;  // see R6
      n.drv.wr_n = ~(b & n.drv.write_gate);
    end

    // a processor load wins over the serializer's take in the same cycle
    if (wld) begin
      n.wbuf = lb_req.wdata;  // see R1
      n.wbuf_v = 1'b1;
    end
  end

  // ********
  // registers and outputs
  // ********
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.gap0 <= GAP0_RST;
      r.gap1 <= GAP1_RST;
      r.gap2 <= GAP2_RST;
      r.secw <= SECW_RST;
      r.drv.wr_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign lb_rsp     = r.rsp;
  assign sel        = r.sel;
  assign drv_out    = r.drv;
  assign err_status = r.err;

endmodule // dsd_datapath
`default_nettype wire

// ==== core/dsd_pkg.sv ====
// Notes on behaviour
// R1 - A local-bus write to address 8028H loads the 16-bit write buffer with the processor's data word.
// R2 - 16-bit local addresses are decoded into ROM, RAM, local I/O and disk selects.
// R3 - On a write, each write-buffer word is shifted out serially to the drive.
// R4 - On a read, serial bits from the drive are gathered into a 16-bit word and put into the read buffer.
// R5 - The write buffer and the read buffer each hold exactly one 16-bit word.
// R6 - Serial data to and from the drive travels as a differential NRZ pair in both directions.
// R7 - Starting a read or write uses the loaded 32-bit target identifier of cylinder, head and sector.
// R8 - Each sector identifier read from the disk is compared with the target, and data moves only after a match.
// R9 - A 32-bit check code follows every written ID and data field.
// R10 - The check code corrects an 11-bit burst and detects a 32-bit burst; the core only flags a mismatch and corrects nothing.
// R11 - Field spacing inside a sector is timed by three counters that count disk clock pulses.
// R12 - The three gap counters are loadable by the processor for different record sizes and gap lengths.
// R13 - Drive control goes out on control lines, drive status comes in, and operations are sequenced from it.
// R14 - A 2K-byte on-board RAM buffers sector data between host transfers and disk transfers; the core's RAM has no path to the disk sequencer.
// R15 - A data-field check error sets error bit 3 and an ID-field check error sets error bit 4.
// R16 - An ID field whose cylinder differs from the expected one sets error bit 6.
// R17 - On reads the check code is recomputed over each ID and data field and any mismatch is flagged.
package dsd_pkg;

  // ********
  // local bus map
  // ********
  localparam logic [15:0] ROM_HI    = 16'h3FFF;
  localparam logic [15:0] RAM_LO    = 16'h4000;
  localparam logic [15:0] RAM_HI    = 16'h47FF;
  localparam logic [15:0] IO_LO     = 16'h8000;
  localparam logic [15:0] IO_HI     = 16'hC0FF;
  localparam logic [15:0] DISK_LO   = 16'h8020;
  localparam logic [15:0] DISK_HI   = 16'h803F;
  localparam logic [15:0] A_RBUF    = 16'h8020;
  localparam logic [15:0] A_STAT    = 16'h8022;
  localparam logic [15:0] A_ERR     = 16'h8024;
  localparam logic [15:0] A_CMD     = 16'h8026;
  localparam logic [15:0] A_WBUF    = 16'h8028;
  localparam logic [15:0] A_TID_LO  = 16'h8030;
  localparam logic [15:0] A_TID_HI  = 16'h8032;
  localparam logic [15:0] A_GAP0    = 16'h8034;
  localparam logic [15:0] A_GAP1    = 16'h8036;
  localparam logic [15:0] A_GAP2    = 16'h8038;
  localparam logic [15:0] A_SECW    = 16'h803A;

  // ********
  // fields, commands, reset values
  // ********
  localparam int ERR_DATA_ECC = 3;
  localparam int ERR_ID_ECC   = 4;
  localparam int ERR_FAULT    = 5;
  localparam int ERR_CYL      = 6;
  localparam logic [1:0] CMD_READ   = 2'h1;
  localparam logic [1:0] CMD_WRITE  = 2'h2;
  localparam logic [1:0] CMD_FORMAT = 2'h3;
  localparam logic [15:0] GAP0_RST  = 16'h0010;
  localparam logic [15:0] GAP1_RST  = 16'h0010;
  localparam logic [15:0] GAP2_RST  = 16'h0010;
  localparam logic [15:0] SECW_RST  = 16'h0100;
  localparam logic [7:0]  TRIES_RST = 8'h10;
  localparam logic [31:0] CRC_INIT  = 32'h00000000;
  localparam logic [31:0] CRC_POLY  = 32'h00A00805;
  localparam int RAM_AW = 10;

  // ********
  // types
  // ********
  typedef enum logic [3:0] {ST_IDLE, ST_START, ST_GAP0, ST_IDF, ST_GAP1, ST_DATF, ST_ECCF, ST_GAP2} dsd_state_t;
  typedef enum logic [2:0] {RG_NONE, RG_ROM, RG_RAM, RG_IO, RG_DISK} dsd_region_t;
  typedef struct packed {logic req; logic we; logic [15:0] addr; logic [15:0] wdata;} dsd_lbus_req_t;
  typedef struct packed {logic ack; logic [15:0] rdata;} dsd_lbus_rsp_t;
  typedef struct packed {logic rom; logic ram; logic io; logic disk;} dsd_sel_t;
  typedef struct packed {logic write_gate; logic read_gate; logic wr_p; logic wr_n;} dsd_drv_out_t;
  typedef struct packed {logic dclk; logic rd_p; logic rd_n; logic ready; logic fault;} dsd_drv_in_t;

endpackage

// ==== core/dsd_fifo2.sv ====
`timescale 1ns/1ns
`default_nettype none
module dsd_fifo2 #(
  parameter int W = 16
) (
  input  wire logic         clk,        // core clock
  input  wire logic         reset_n,    // async reset, active low
  input  wire logic         in_valid,   // word offered
  input  wire logic [W-1:0] in_data,    // offered word
  output var  logic         in_ready,   // room for a word
  output var  logic         out_valid,  // word waiting
  output var  logic [W-1:0] out_data,   // oldest word
  input  wire logic         out_ready   // drain takes the word
);
  typedef struct packed {logic [1:0][W-1:0] mem; logic wp; logic rp; logic [1:0] cnt;} dsd_fifo_t;
  dsd_fifo_t r;
  dsd_fifo_t n;

  // two entries so one stalled drain cycle never drops a word
  always_comb begin
    n = r;
    if (in_valid && in_ready) begin
      n.mem[r.wp] = in_data;
      n.wp = ~r.wp;
    end
    if (out_valid && out_ready) begin
      n.rp = ~r.rp;
    end
    n.cnt = r.cnt + 2'((in_valid && in_ready) ? 1 : 0) - 2'((out_valid && out_ready) ? 1 : 0);
  end

  assign in_ready  = (r.cnt != 2'h2);
  assign out_valid = (r.cnt != 2'h0);
  assign out_data  = r.mem[r.rp];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule // dsd_fifo2
`default_nettype wire

// ==== core/dsd_ram.sv ====
`timescale 1ns/1ns
`default_nettype none
module dsd_ram #(
  parameter int AW = 10,
  parameter int DW = 16
) (
  input  wire logic          clk,    // core clock
  input  wire logic          we,     // write strobe
  input  wire logic [AW-1:0] addr,   // word address
  input  wire logic [DW-1:0] wdata,  // write data
  output var  logic [DW-1:0] rdata   // registered read data
);
  logic [DW-1:0] mem [2**AW];

  // sector buffer; contents are undefined until written
  always_ff @(posedge clk) begin
    rdata <= mem[addr];
    if (we) begin
      mem[addr] <= wdata;
    end
  end
endmodule // dsd_ram
`default_nettype wire

// ==== bench/dsd_datapath_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module dsd_datapath_checker import dsd_pkg::*; #(
  parameter logic [31:0] POLY  = CRC_POLY,  // as the design
  parameter logic [7:0]  TRIES = TRIES_RST  // as the design
) (
  input wire logic          clk,        // core clock
  input wire logic          reset_n,    // async reset, active low
  input wire dsd_lbus_req_t lb_req,     // local bus request
  input wire dsd_lbus_rsp_t lb_rsp,     // local bus answer
  input wire dsd_sel_t      sel,        // select strobes
  input wire dsd_drv_in_t   drv_in,     // drive pins in
  input wire dsd_drv_out_t  drv_out,    // drive pins out
  input wire logic [7:0]    err_status  // error byte
);
  // ******
  // port relations
  // ******
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_wbuf;
    lb_req.req && lb_req.we && lb_req.addr == A_WBUF |=> lb_rsp.ack && sel.disk;
  endproperty
  a_wbuf: assert property (p_wbuf) else $error("wbuf load unanswered");
  property p_ram_sel;
    lb_req.req && lb_req.addr inside {[RAM_LO:RAM_HI]} |=> sel == 4'h4;
  endproperty
  a_ram_sel: assert property (p_ram_sel) else $error("ram select wrong");
  property p_rom;
    lb_req.req && lb_req.addr <= ROM_HI |=> sel == 4'h8 && !lb_rsp.ack ##1 !lb_rsp.ack;
  endproperty
  a_rom: assert property (p_rom) else $error("rom decode wrong");
  property p_ram_rd;
    lb_req.req && !lb_req.we && lb_req.addr inside {[RAM_LO:RAM_HI]} |=> !lb_rsp.ack ##1 lb_rsp.ack;
  endproperty
  a_ram_rd: assert property (p_ram_rd) else $error("ram read late");
  property p_ack;
    lb_rsp.ack |-> $past(lb_req.req) || $past(lb_req.req, 2);
  endproperty
  a_ack: assert property (p_ack) else $error("stray answer");
  property p_pair;
    drv_out.wr_p != drv_out.wr_n;
  endproperty
  a_pair: assert property (p_pair) else $error("write pair equal");
  property p_ready;
    $rose(drv_out.read_gate || drv_out.write_gate) |-> $past(drv_in.ready, 3);
  endproperty
  a_ready: assert property (p_ready) else $error("gate without ready");
  property p_fault_gate;
    drv_in.fault [*8] |-> !drv_out.read_gate && !drv_out.write_gate;
  endproperty
  a_fault_gate: assert property (p_fault_gate) else $error("gate open during fault");
  property p_fault_err;
    drv_in.fault && (drv_out.read_gate || drv_out.write_gate) |-> ##[1:8] err_status[ERR_FAULT];
  endproperty
  a_fault_err: assert property (p_fault_err) else $error("fault not flagged");
  // check errors come only from reads
  property p_err_src;
    $rose(err_status[ERR_CYL]) || $rose(err_status[ERR_ID_ECC]) || $rose(err_status[ERR_DATA_ECC])
      |-> $past(drv_out.read_gate) || $past(drv_out.read_gate, 2);
  endproperty
  a_err_src: assert property (p_err_src) else $error("error outside read");
endmodule // dsd_datapath_checker
`default_nettype wire

// ==== bench/dsd_drive_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module dsd_drive_model (
  output var  logic dclk,        // disk clock, still outside frames
  output var  logic rd_p,        // read pair, true side
  output var  logic rd_n,        // read pair, inverted side
  input  wire logic read_gate,   // controller reading
  input  wire logic write_gate,  // controller writing
  input  wire logic wr_p,        // write pair, true side
  input  wire logic wr_n         // write pair, inverted side
);
  logic tx_q[$];  // bits played to the reader
  logic rx_q[$];  // bits recorded from the writer
  logic b;
  // ******
  // frame engine
  // ******
  // clock runs only while a gate is open; offset keeps edges off core edges
  initial begin
    dclk = 1'b0;
    b = 1'b0;
    rd_p = 1'b0;
    rd_n = 1'b1;
    forever begin
      wait (read_gate || write_gate);
      #37;
      while (read_gate || write_gate) begin
        b = (tx_q.size() > 0) ? tx_q.pop_front() : ~b;  // empty queue toggles
        rd_p = b;
        rd_n = ~b;
        #400 dclk = 1'b1;
        if (write_gate)
          rx_q.push_back(wr_p & ~wr_n);
        #400 dclk = 1'b0;
      end
      rd_p = ~b;  // released pair shows the inverse of the last bit
      rd_n = b;
    end
  end
endmodule // dsd_drive_model
`default_nettype wire

// ==== bench/dsd_datapath_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module dsd_datapath_tb_top import dsd_pkg::*; ;
  localparam logic [7:0] TR = 8'h02;  // short retry count keeps not-found runs brief
  logic          clk = 1'b0;
  logic          reset_n = 1'b0;
  logic          ready = 1'b1;
  logic          fault = 1'b0;
  logic          flt = 1'b0;
  logic          ak, e, dclk, rd_p, rd_n;
  dsd_lbus_req_t lb_req = '0;
  dsd_lbus_rsp_t lb_rsp;
  dsd_sel_t      sel;
  dsd_drv_in_t   drv_in;
  dsd_drv_out_t  drv_out;
  logic [7:0]    err_status;
  logic [31:0]   seed = 32'h69C20BD6;
  logic [31:0]   tid, r;
  logic [15:0]   q, st, w[4];
  logic [15:0]   amap[9] = '{16'h0000, 16'h3FFE, 16'h4000, 16'h47FE, 16'h5000, 16'h8000, 16'hC0FE, 16'h803E, A_ERR};
  logic [7:0]    em[4] = '{8'hFF, 8'hFF, 8'h10, 8'h40};
  logic [7:0]    ee[4] = '{8'h00, 8'h08, 8'h10, 8'h40};
  int            errors = 0;
  int            total_checks = 0;

  always #50 clk = ~clk;
  assign drv_in = '{dclk: dclk, rd_p: rd_p, rd_n: rd_n, ready: ready, fault: fault};
  dsd_datapath #(.TRIES(TR)) i_dut (.clk(clk), .reset_n(reset_n), .lb_req(lb_req), .lb_rsp(lb_rsp),
    .sel(sel), .drv_in(drv_in), .drv_out(drv_out), .err_status(err_status));
  dsd_drive_model i_drv (.dclk(dclk), .rd_p(rd_p), .rd_n(rd_n), .read_gate(drv_out.read_gate),
    .write_gate(drv_out.write_gate), .wr_p(drv_out.wr_p), .wr_n(drv_out.wr_n));

  // ******
  // helpers
  // ******
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // serial check code, msb first
  function automatic logic [31:0] crc(input logic [63:0] v, input int n);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = n - 1; i >= 0; i--)
      c = {c[30:0], 1'b0} ^ (((c[31] ^ v[i]) == 1'b1) ? CRC_POLY : 32'h0);
    return c;
  endfunction
  // gap bits are unknown: search the recorded stream
  function automatic logic found(input logic [63:0] v, input int n);
    int k;
    for (int p = 0; p + n <= i_drv.rx_q.size(); p++) begin
      k = 0;
      while (k < n && i_drv.rx_q[p + k] === v[n - 1 - k])
        k++;
      if (k == n)
        return 1'b1;
    end
    return 1'b0;
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one-cycle request; answer within three cycles
  task automatic bus(input logic wt, input logic [15:0] a, input logic [15:0] d);
    lb_req <= '{req: 1'b1, we: wt, addr: a, wdata: d};
    @(posedge clk);
    lb_req.req <= 1'b0;
    ak = 1'b0;
    repeat (3) begin
      @(posedge clk);
      if (lb_rsp.ack === 1'b1) begin
        ak = 1'b1;
        q = lb_rsp.rdata;
      end
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a);
    bus(1'b0, a, 16'h0000);
  endtask
  task automatic push(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      i_drv.tx_q.push_back(v[i]);
  endtask
  // start a command, maybe delay ready or inject a fault, wait for done
  task automatic run(input logic [1:0] c);
    int n;
    wr(A_CMD, {14'h0000, c});
    if (ready === 1'b0) begin
      repeat (30) @(posedge clk);
      chk(drv_out.read_gate, 1'b0);
      ready <= 1'b1;
    end
    for (n = 0; flt && drv_out.read_gate !== 1'b1 && n < 50; n++)
      @(posedge clk);
    fault <= flt;
    st = 16'h0000;
    for (n = 0; st[1] !== 1'b1 && n < 3000; n++) begin
      rd(A_STAT);
      st = q;
    end
    chk(n < 3000, 1'b1);
    wr(A_STAT, 16'h0072);
  endtask
  task automatic end_of_test();
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ******
  // scenarios
  // ******
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk({err_status, drv_out}, 12'h001);
    // only RAM and the disk window answer; the error byte ignores writes
    foreach (amap[i]) begin
      e = amap[i] inside {[RAM_LO:RAM_HI], [DISK_LO:DISK_HI]};
      wr(amap[i], 16'hFFFF);
      rd(amap[i]);
      chk(ak, e);
      if (e)
        chk(q, (amap[i] < DISK_LO) ? 16'hFFFF : 16'h0000);
    end
    repeat (8) begin
      r = rnd();
      wr({5'h08, r[9:0], 1'b0}, r[31:16]);
      rd({5'h08, r[9:0], 1'b0});
      chk(q, r[31:16]);
    end
    wr(A_GAP0, 16'h0000);
    wr(A_GAP1, 16'h0000);
    wr(A_GAP2, 16'h0000);
    wr(A_SECW, 16'h0004);
    // reads: clean, bad data code, bad id code, wrong cylinder; four words overrun the buffers
    for (int k = 0; k < 4; k++) begin
      ready <= (k != 0);
      tid = rnd();
      r = tid ^ ((k == 3) ? 32'h00010000 : 32'h0);
      {w[0], w[1]} = rnd();
      {w[2], w[3]} = rnd();
      wr(A_TID_LO, tid[15:0]);
      wr(A_TID_HI, tid[31:16]);
      i_drv.tx_q.delete();
      push(64'h0, 1);
      push(64'(r), 32);
      push(64'(crc(64'(r), 32) ^ 32'(k == 2)), 32);
      push(64'h0, 1);
      push({w[0], w[1], w[2], w[3]}, 64);
      push(64'(crc({w[0], w[1], w[2], w[3]}, 64) ^ 32'(k == 1)), 32);
      run(CMD_READ);
      chk(err_status & em[k], ee[k]);
      chk(st[6:5], (k < 2) ? 2'h1 : 2'h2);
      for (int j = 0; j < 3; j++) begin
        rd(A_RBUF);
        if (k < 2)
          chk(q, w[j]);
      end
      rd(A_STAT);
      chk(q[3], 1'b0);
    end
    // write then format of a one-word sector
    wr(A_SECW, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      r = rnd();
      wr(A_WBUF, r[15:0]);
      rd(A_STAT);
      chk(q[2], 1'b1);
      i_drv.tx_q.delete();
      i_drv.rx_q.delete();
      push(64'h0, 1);
      push(64'(tid), 32);
      push(64'(crc(64'(tid), 32)), 32);
      run((k == 1) ? CMD_FORMAT : CMD_WRITE);
      chk(found(64'({r[15:0], crc(64'(r[15:0]), 16)}), 48), 1'b1);
      chk(found({tid, crc(64'(tid), 32)}, 64), k == 1);
      chk(st[4], 1'b0);
    end
    flt = 1'b1;
    run(CMD_READ);
    chk(err_status[ERR_FAULT], 1'b1);
    chk(drv_out[3:2], 2'h0);
    fault <= 1'b0;
    end_of_test();
  end
  // watchdog far past the expected run
  initial begin
    #6000000;
    errors++;
    end_of_test();
  end
endmodule // dsd_datapath_tb_top
bind dsd_datapath dsd_datapath_checker #(.POLY(POLY), .TRIES(TRIES)) i_chk (.clk(clk), .reset_n(reset_n),
  .lb_req(lb_req), .lb_rsp(lb_rsp), .sel(sel), .drv_in(drv_in), .drv_out(drv_out), .err_status(err_status));
`default_nettype wire
